// [dcsp_pkg.sv]
package dcsp_pkg;
    // character length select
    localparam logic [1:0] DCSP_LEN7 = 2'h0;
    localparam logic [1:0] DCSP_LEN8 = 2'h1;
    localparam logic [1:0] DCSP_LEN9 = 2'h2;
    // parity select
    localparam logic [1:0] DCSP_PAR_NONE = 2'h0;
    localparam logic [1:0] DCSP_PAR_ZERO = 2'h1;
    localparam logic [1:0] DCSP_PAR_EVEN = 2'h2;
    localparam logic [1:0] DCSP_PAR_ODD = 2'h3;
    localparam int DCSP_DATA_W = 9;
    localparam int DCSP_DIV_W = 16;
    localparam logic [15:0] DCSP_DIV_RESET = 16'h0015;
    localparam logic [8:0] DCSP_DATA_RESET = 9'h000;
    localparam logic [3:0] DCSP_BIT_RESET = 4'h0;
    localparam logic DCSP_LINE_IDLE = 1'b1;
    typedef enum {DCSP_IDLE, DCSP_START, DCSP_DATA, DCSP_PARITY, DCSP_STOP} dcsp_state_type;
endpackage

// [dcsp_props.sv]
`timescale 1ns/10ps
module dcsp_props
    import dcsp_pkg::*;
#(
    parameter bit NINE_BIT_OK = 1'b1,
    parameter int DW = DCSP_DIV_W
) (
    input wire logic MCLK, // clock
    input wire logic RST, // reset
    input wire logic [1:0] CHAR_LEN, // length
    input wire logic LINE_INVERT, // inversion
    input wire logic CONT_MODE, // continuous
    input wire logic TX_WRITE, // write strobe
    input wire logic TX_BUSY, // shifting
    input wire logic TXD, // serial out
    input wire logic [8:0] RX_DATA, // rx data
    input wire logic RX_VALID, // unread
    input wire logic TX_INTERRUPT, // tx irq
    input wire logic RX_DONE_INTERRUPT, // rx irq
    input wire logic RX_ERROR_INTERRUPT, // err irq
    input wire logic PARITY_ERROR, // flag
    input wire logic FRAMING_ERROR, // flag
    input wire logic OVERRUN_ERROR, // flag
    input wire logic PARITY_ERROR_CLEAR, // clear
    input wire logic FRAMING_ERROR_CLEAR, // clear
    input wire logic OVERRUN_ERROR_CLEAR // clear
);
    logic [2:0] e_flags;
    logic [2:0] e_clr;
    assign e_flags = {PARITY_ERROR, FRAMING_ERROR, OVERRUN_ERROR};
    assign e_clr = {PARITY_ERROR_CLEAR, FRAMING_ERROR_CLEAR, OVERRUN_ERROR_CLEAR};
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    a_tx_pulse_once: assert property (TX_INTERRUPT |=> !TX_INTERRUPT)
        else $error("tx interrupt too long");
    a_tx_single_end: assert property (TX_INTERRUPT && !CONT_MODE |->
        TXD == !LINE_INVERT && $past(TXD) == !LINE_INVERT) else $error("tx end too early");
    a_tx_cont_load: assert property (TX_INTERRUPT && CONT_MODE |->
        TX_BUSY ##1 TXD == LINE_INVERT) else $error("tx load without start bit");
    a_tx_start_delay: assert property (TX_WRITE && !TX_BUSY && !$past(TX_WRITE) |->
        ##3 TXD == LINE_INVERT) else $error("no start bit after write");
    a_tx_idle_level: assert property (!TX_BUSY && $stable(LINE_INVERT) |->
        TXD == !LINE_INVERT) else $error("idle level wrong");
    a_rx_done_valid: assert property (RX_DONE_INTERRUPT |-> RX_VALID)
        else $error("done without data");
    a_err_flag_irq: assert property ($rose(|e_flags) || RX_ERROR_INTERRUPT |->
        RX_ERROR_INTERRUPT && e_flags != 3'h0) else $error("error irq and flags apart");
    a_err_then_done: assert property (RX_ERROR_INTERRUPT |-> RX_DONE_INTERRUPT)
        else $error("error without done");
    a_err_sticky: assert property ((($past(e_flags) & ~$past(e_clr)) & ~e_flags) == 3'h0)
        else $error("error flag dropped");
    a_err_clear: assert property ((e_flags & $past(e_clr)) == 3'h0 || RX_ERROR_INTERRUPT)
        else $error("error flag not cleared");
    a_rx_char_width: assert property (RX_DONE_INTERRUPT && CHAR_LEN != DCSP_LEN9 |->
        !RX_DATA[8] && (CHAR_LEN != DCSP_LEN7 || !RX_DATA[7])) else $error("data too wide");
    cover property (TX_INTERRUPT && CONT_MODE);
    cover property ($rose(OVERRUN_ERROR));
    cover property (RX_ERROR_INTERRUPT && FRAMING_ERROR);
endmodule

bind dcsp_top dcsp_props #(.NINE_BIT_OK(NINE_BIT_OK), .DW(DW)) u_props (.MCLK(MCLK), .RST(RST),
    .CHAR_LEN(CHAR_LEN), .LINE_INVERT(LINE_INVERT), .CONT_MODE(CONT_MODE), .TX_WRITE(TX_WRITE),
    .TX_BUSY(TX_BUSY), .TXD(TXD), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .TX_INTERRUPT(TX_INTERRUPT), .RX_DONE_INTERRUPT(RX_DONE_INTERRUPT),
    .RX_ERROR_INTERRUPT(RX_ERROR_INTERRUPT), .PARITY_ERROR(PARITY_ERROR),
    .FRAMING_ERROR(FRAMING_ERROR), .OVERRUN_ERROR(OVERRUN_ERROR),
    .PARITY_ERROR_CLEAR(PARITY_ERROR_CLEAR), .FRAMING_ERROR_CLEAR(FRAMING_ERROR_CLEAR),
    .OVERRUN_ERROR_CLEAR(OVERRUN_ERROR_CLEAR));

// [dcsp_remote.sv]
`timescale 1ns/10ps
module dcsp_remote #(
    parameter int BT = 6 // clocks per bit
) (
    input wire logic clk, // clock
    input wire logic inv, // line inversion
    input wire logic [3:0] nb, // bits after start to capture
    input wire logic line_in, // device serial output
    output logic line_out, // device serial input
    output logic [11:0] got, // last frame, lsb first
    output logic got_ev // toggles per frame
);
    logic tx_bit = 1'b1;
    logic [11:0] w;
    assign line_out = tx_bit ^ inv;
    initial got_ev = 1'b0;
    initial got = 12'h000;
    ////////////////////////////////////////
    task automatic send(input logic [11:0] f, input int n, input int start_len);
        @(posedge clk);
        tx_bit <= 1'b0;
        repeat (start_len) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            tx_bit <= f[i];
            repeat (BT) @(posedge clk);
        end
        tx_bit <= 1'b1;
    endtask
    // two low samples in a row, so an inversion change is not a start
    always begin
        @(posedge clk iff (line_in ^ inv) == 1'b0);
        @(posedge clk);
        if ((line_in ^ inv) == 1'b0) begin
            w = 12'hFFF;
            repeat (BT / 2 - 1) @(posedge clk);
            for (int i = 0; i < nb; i++) begin
                repeat (BT) @(posedge clk);
                w[i] = line_in ^ inv;
            end
            got = w;
            got_ev = ~got_ev;
        end
    end
endmodule

// [dcsp_skid_buf.sv]
`timescale 1ns/10ps
module dcsp_skid_buf
    import dcsp_pkg::*;
#(
    parameter int W = DCSP_DATA_W
) (
    input wire logic clk, // clock
    input wire logic rst, // async reset
    dcsp_stream_if.snk in_s, // filling side
    dcsp_stream_if.src out_s // draining side
);
    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0] cnt_reg, cnt_next;
    logic push, pop;
    assign in_s.ready = (cnt_reg != 2'h2);
    assign out_s.valid = (cnt_reg != 2'h0);
    assign out_s.data = mem_reg[rp_reg];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;
    always_comb begin
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wp_reg] = in_s.data;
            wp_next = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 2'h1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 2'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// [dcsp_stream_if.sv]
`timescale 1ns/10ps
interface dcsp_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [dcsp_top.sv]
// Functional notes
// - character length of seven, eight or nine data bits is selectable.
// - nine-bit length only where the instance parameter allows it.
// - parity none, forced zero, even or odd.
// - transmitter sends one or two stop bits; receiver checks one.
// - one inversion control flips tx output and rx input; default off.
// - noise filter accepts a level after two agreeing clock samples.
// - characters sit in the low seven, eight or nine data bits.
// - receiver assembles a character only after a start bit.
// - one tx interrupt, transfer end or buffer empty by mode.
// - continuous mode signals buffer empty for back-to-back refill.
// - single mode raises tx interrupt after the last stop bit.
// - continuous mode raises tx interrupt on buffer-to-shifter transfer.
// - receive done interrupt fires at the stop bit.
// - receive done fires even with parity or framing error.
// - receive done interrupt also fires on overrun.
// - separate error interrupt on parity, framing or overrun.
// - even channel only transmits, odd channel only receives.
// - error flags hold until a one is written to their clear input.
`timescale 1ns/10ps
module dcsp_top
    import dcsp_pkg::*;
#(
    parameter bit NINE_BIT_OK = 1'b1, // instance may use nine-bit length
    parameter int DW = DCSP_DIV_W // bit divider width
) (
    input wire logic MCLK, // channel operating clock
    input wire logic RST, // async reset, high
    input wire logic [DW-1:0] BIT_DIV, // clocks per bit minus one
    input wire logic [1:0] CHAR_LEN, // character length select
    input wire logic [1:0] PARITY_SEL, // parity select
    input wire logic TWO_STOP, // transmit two stop bits
    input wire logic LINE_INVERT, // invert tx and rx levels
    input wire logic RX_NOISE_FILTER_ENABLE, // two-sample filter on rx
    input wire logic CONT_MODE, // continuous transmission mode
    input wire logic [8:0] TX_DATA, // write data of tx channel data register
    input wire logic TX_WRITE, // write strobe of tx data register
    output logic TX_READY, // tx data register can take a write
    output logic TX_BUSY, // tx channel shifting
    output logic TXD, // serial output
    input wire logic RXD, // serial input pin
    output logic [8:0] RX_DATA, // rx channel data register
    input wire logic RX_READ, // read strobe of rx data register
    output logic RX_VALID, // rx data register holds unread character
    output logic TX_INTERRUPT, // tx interrupt pulse
    output logic RX_DONE_INTERRUPT, // rx done interrupt pulse
    output logic RX_ERROR_INTERRUPT, // rx error interrupt pulse
    output logic PARITY_ERROR, // parity error flag
    output logic FRAMING_ERROR, // framing error flag
    output logic OVERRUN_ERROR, // overrun error flag
    input wire logic PARITY_ERROR_CLEAR, // write one clears parity flag
    input wire logic FRAMING_ERROR_CLEAR, // write one clears framing flag
    input wire logic OVERRUN_ERROR_CLEAR // write one clears overrun flag
);
    ////////////////////////////////////////////////////////////////////////
    // configuration decode
    logic [3:0] nbits;
    always_comb begin
        nbits = 4'h8;
        if (CHAR_LEN == DCSP_LEN7) begin
            nbits = 4'h7;
        end else if (CHAR_LEN == DCSP_LEN9 && NINE_BIT_OK) begin
            nbits = 4'h9;
        end
    end
    function automatic logic [8:0] dmask(input logic [3:0] n);
        dmask = (n == 4'h7) ? 9'h07F : (n == 4'h8) ? 9'h0FF : 9'h1FF;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // transmit channel (even) with two-entry buffer
    dcsp_stream_if #(.W(DCSP_DATA_W)) wr_s ();
    dcsp_stream_if #(.W(DCSP_DATA_W)) sh_s ();
    logic tx_ready_reg, tx_ready_next;
    assign wr_s.valid = TX_WRITE;
    assign wr_s.data = TX_DATA & dmask(nbits);
    dcsp_skid_buf #(.W(DCSP_DATA_W)) u_txbuf (
        .clk(MCLK),
        .rst(RST),
        .in_s(wr_s.snk),
        .out_s(sh_s.src)
    );
    dcsp_state_type ts_reg, ts_next;
    logic [DW-1:0] tcnt_reg, tcnt_next;
    logic [3:0] tbit_reg, tbit_next;
    logic [8:0] tsh_reg, tsh_next;
    logic tpar_reg, tpar_next;
    logic txd_reg, txd_next;
    logic tint_reg, tint_next;
    logic tbusy_reg, tbusy_next;
    logic tline;
    always_comb begin
        ts_next = ts_reg;
        tcnt_next = tcnt_reg;
        tbit_next = tbit_reg;
        tsh_next = tsh_reg;
        tpar_next = tpar_reg;
        tint_next = 1'b0;
        tline = DCSP_LINE_IDLE;
        sh_s.ready = 1'b0;
        tx_ready_next = wr_s.ready;
        case (ts_reg)
            DCSP_IDLE: begin
                if (sh_s.valid) begin
                    sh_s.ready = 1'b1;
                    tsh_next = sh_s.data;
                    tpar_next = 1'b0;
                    tcnt_next = BIT_DIV;
                    ts_next = DCSP_START;
                    tint_next = CONT_MODE;
                end
            end
            DCSP_START: begin
                tline = 1'b0;
                if (tcnt_reg == '0) begin
                    tcnt_next = BIT_DIV;
                    tbit_next = DCSP_BIT_RESET;
                    ts_next = DCSP_DATA;
                end else begin
                    tcnt_next = tcnt_reg - 1'b1;
                end
            end
            DCSP_DATA: begin
                tline = tsh_reg[0];
                if (tcnt_reg == '0) begin
                    tcnt_next = BIT_DIV;
                    tpar_next = tpar_reg ^ tsh_reg[0];
                    tsh_next = {1'b0, tsh_reg[8:1]};
                    tbit_next = tbit_reg + 4'h1;
                    if (tbit_reg == nbits - 4'h1) begin
                        tbit_next = DCSP_BIT_RESET;
                        ts_next = (PARITY_SEL == DCSP_PAR_NONE) ? DCSP_STOP : DCSP_PARITY;
                    end
                end else begin
                    tcnt_next = tcnt_reg - 1'b1;
                end
            end
            DCSP_PARITY: begin
                case (PARITY_SEL)
                    DCSP_PAR_EVEN: tline = tpar_reg;
                    DCSP_PAR_ODD: tline = ~tpar_reg;
                    default: tline = 1'b0;
                endcase
                if (tcnt_reg == '0) begin
                    tcnt_next = BIT_DIV;
                    ts_next = DCSP_STOP;
                end else begin
                    tcnt_next = tcnt_reg - 1'b1;
                end
            end
            DCSP_STOP: begin
                if (tcnt_reg == '0) begin
                    tcnt_next = BIT_DIV;
                    if (TWO_STOP && tbit_reg == 4'h0) begin
                        tbit_next = 4'h1;
                    end else begin
                        ts_next = DCSP_IDLE;
                        tint_next = ~CONT_MODE;
                    end
                end else begin
                    tcnt_next = tcnt_reg - 1'b1;
                end
            end
            default: ts_next = DCSP_IDLE;
        endcase
        txd_next = tline ^ LINE_INVERT;
        tbusy_next = (ts_next != DCSP_IDLE);
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ts_reg <= DCSP_IDLE;
            tcnt_reg <= '0;
            tbit_reg <= DCSP_BIT_RESET;
            tsh_reg <= DCSP_DATA_RESET;
            tpar_reg <= 1'b0;
            txd_reg <= DCSP_LINE_IDLE;
            tint_reg <= 1'b0;
            tbusy_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
        end else begin
            ts_reg <= ts_next;
            tcnt_reg <= tcnt_next;
            tbit_reg <= tbit_next;
            tsh_reg <= tsh_next;
            tpar_reg <= tpar_next;
            txd_reg <= txd_next;
            tint_reg <= tint_next;
            tbusy_reg <= tbusy_next;
            tx_ready_reg <= tx_ready_next;
        end
    end
    assign TXD = txd_reg;
    assign TX_INTERRUPT = tint_reg;
    assign TX_BUSY = tbusy_reg;
    assign TX_READY = tx_ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // receive line synchroniser and noise filter
    logic rs1_reg, rs2_reg, rs3_reg, rflt_reg, rflt_next;
    always_comb begin
        rflt_next = rflt_reg;
        if (!RX_NOISE_FILTER_ENABLE) begin
            rflt_next = rs2_reg ^ LINE_INVERT;
        end else if (rs2_reg == rs3_reg) begin
            rflt_next = rs2_reg ^ LINE_INVERT;
        end
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rs1_reg <= DCSP_LINE_IDLE;
            rs2_reg <= DCSP_LINE_IDLE;
            rs3_reg <= DCSP_LINE_IDLE;
            rflt_reg <= DCSP_LINE_IDLE;
        end else begin
            rs1_reg <= RXD;
            rs2_reg <= rs1_reg;
            rs3_reg <= rs2_reg;
            rflt_reg <= rflt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive channel (odd), independent of transmit
    dcsp_state_type rs_reg, rs_next;
    logic [DW-1:0] rcnt_reg, rcnt_next;
    logic [3:0] rbit_reg, rbit_next;
    logic [8:0] rsh_reg, rsh_next;
    logic rpar_reg, rpar_next, rperr_reg, rperr_next;
    logic [8:0] rdat_reg, rdat_next;
    logic rval_reg, rval_next;
    logic rdone_reg, rdone_next, rerr_reg, rerr_next;
    logic pe_reg, pe_next, fe_reg, fe_next, ov_reg, ov_next;
    logic set_pe, set_fe, set_ov;
    always_comb begin
        rs_next = rs_reg;
        rcnt_next = rcnt_reg;
        rbit_next = rbit_reg;
        rsh_next = rsh_reg;
        rpar_next = rpar_reg;
        rperr_next = rperr_reg;
        rdat_next = rdat_reg;
        rval_next = rval_reg & ~RX_READ;
        set_pe = 1'b0;
        set_fe = 1'b0;
        set_ov = 1'b0;
        rdone_next = 1'b0;
        case (rs_reg)
            DCSP_IDLE: begin
                if (!rflt_reg) begin
                    rcnt_next = {1'b0, BIT_DIV[DW-1:1]};
                    rs_next = DCSP_START;
                end
            end
            DCSP_START: begin
                if (rcnt_reg == '0) begin
                    rcnt_next = BIT_DIV;
                    rbit_next = DCSP_BIT_RESET;
                    rsh_next = DCSP_DATA_RESET;
                    rpar_next = 1'b0;
                    rs_next = rflt_reg ? DCSP_IDLE : DCSP_DATA;
                end else begin
                    rcnt_next = rcnt_reg - 1'b1;
                end
            end
            DCSP_DATA: begin
                if (rcnt_reg == '0) begin
                    rcnt_next = BIT_DIV;
                    rsh_next[rbit_reg] = rflt_reg;
                    rpar_next = rpar_reg ^ rflt_reg;
                    rbit_next = rbit_reg + 4'h1;
                    rperr_next = 1'b0;
                    if (rbit_reg == nbits - 4'h1) begin
                        rs_next = (PARITY_SEL == DCSP_PAR_NONE) ? DCSP_STOP : DCSP_PARITY;
                    end
                end else begin
                    rcnt_next = rcnt_reg - 1'b1;
                end
            end
            DCSP_PARITY: begin
                if (rcnt_reg == '0) begin
                    rcnt_next = BIT_DIV;
                    case (PARITY_SEL)
                        DCSP_PAR_EVEN: rperr_next = rpar_reg ^ rflt_reg;
                        DCSP_PAR_ODD: rperr_next = ~(rpar_reg ^ rflt_reg);
                        default: rperr_next = rflt_reg;
                    endcase
                    rs_next = DCSP_STOP;
                end else begin
                    rcnt_next = rcnt_reg - 1'b1;
                end
            end
            DCSP_STOP: begin
                if (rcnt_reg == '0) begin
                    rs_next = DCSP_IDLE;
                    rdat_next = rsh_reg & dmask(nbits);
                    rval_next = 1'b1;
                    rdone_next = 1'b1;
                    set_pe = rperr_reg;
                    set_fe = ~rflt_reg;
                    set_ov = rval_reg & ~RX_READ;
                end else begin
                    rcnt_next = rcnt_reg - 1'b1;
                end
            end
            default: rs_next = DCSP_IDLE;
        endcase
        pe_next = set_pe | (pe_reg & ~PARITY_ERROR_CLEAR);
        fe_next = set_fe | (fe_reg & ~FRAMING_ERROR_CLEAR);
        ov_next = set_ov | (ov_reg & ~OVERRUN_ERROR_CLEAR);
        rerr_next = set_pe | set_fe | set_ov;
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rs_reg <= DCSP_IDLE;
            rcnt_reg <= '0;
            rbit_reg <= DCSP_BIT_RESET;
            rsh_reg <= DCSP_DATA_RESET;
            rpar_reg <= 1'b0;
            rperr_reg <= 1'b0;
            rdat_reg <= DCSP_DATA_RESET;
            rval_reg <= 1'b0;
            rdone_reg <= 1'b0;
            rerr_reg <= 1'b0;
            pe_reg <= 1'b0;
            fe_reg <= 1'b0;
            ov_reg <= 1'b0;
        end else begin
            rs_reg <= rs_next;
            rcnt_reg <= rcnt_next;
            rbit_reg <= rbit_next;
            rsh_reg <= rsh_next;
            rpar_reg <= rpar_next;
            rperr_reg <= rperr_next;
            rdat_reg <= rdat_next;
            rval_reg <= rval_next;
            rdone_reg <= rdone_next;
            rerr_reg <= rerr_next;
            pe_reg <= pe_next;
            fe_reg <= fe_next;
            ov_reg <= ov_next;
        end
    end
    assign RX_DATA = rdat_reg;
    assign RX_VALID = rval_reg;
    assign RX_DONE_INTERRUPT = rdone_reg;
    assign RX_ERROR_INTERRUPT = rerr_reg;
    assign PARITY_ERROR = pe_reg;
    assign FRAMING_ERROR = fe_reg;
    assign OVERRUN_ERROR = ov_reg;
endmodule

// [test_dual_channel_async_serial_port.sv]
`timescale 1ns/10ps
module test_dual_channel_async_serial_port;
    import dcsp_pkg::*;
    localparam int BT = 6;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [15:0] BIT_DIV = 16'h0005;
    logic [1:0] CHAR_LEN = DCSP_LEN8;
    logic [1:0] PARITY_SEL = DCSP_PAR_NONE;
    logic TWO_STOP = 1'b0;
    logic LINE_INVERT = 1'b0;
    logic RX_NOISE_FILTER_ENABLE = 1'b0;
    logic CONT_MODE = 1'b0;
    logic [8:0] TX_DATA = 9'h000;
    logic TX_WRITE = 1'b0;
    logic RX_READ = 1'b0;
    logic [2:0] clr = 3'h0;
    logic TX_READY, TX_BUSY, TXD, RXD, RX_VALID, TX_INTERRUPT, RX_DONE_INTERRUPT;
    logic RX_ERROR_INTERRUPT, PARITY_ERROR, FRAMING_ERROR, OVERRUN_ERROR, got_ev;
    logic [8:0] RX_DATA;
    logic [11:0] got;
    logic [3:0] tx_nb;
    logic [31:0] lfsr = 32'h42DB0A8B;
    logic auto_read = 1'b1;
    int error_cnt = 0;
    int comparisons = 0;
    int irq_cnt = 0;
    int irq_exp = 0;
    logic [11:0] tx_q[$];
    logic [11:0] rx_q[$];

    always #12.5 MCLK = ~MCLK;

    dcsp_top dut (.MCLK(MCLK), .RST(RST), .BIT_DIV(BIT_DIV), .CHAR_LEN(CHAR_LEN),
        .PARITY_SEL(PARITY_SEL), .TWO_STOP(TWO_STOP), .LINE_INVERT(LINE_INVERT),
        .RX_NOISE_FILTER_ENABLE(RX_NOISE_FILTER_ENABLE), .CONT_MODE(CONT_MODE),
        .TX_DATA(TX_DATA), .TX_WRITE(TX_WRITE), .TX_READY(TX_READY), .TX_BUSY(TX_BUSY),
        .TXD(TXD), .RXD(RXD), .RX_DATA(RX_DATA), .RX_READ(RX_READ), .RX_VALID(RX_VALID),
        .TX_INTERRUPT(TX_INTERRUPT), .RX_DONE_INTERRUPT(RX_DONE_INTERRUPT),
        .RX_ERROR_INTERRUPT(RX_ERROR_INTERRUPT), .PARITY_ERROR(PARITY_ERROR),
        .FRAMING_ERROR(FRAMING_ERROR), .OVERRUN_ERROR(OVERRUN_ERROR),
        .PARITY_ERROR_CLEAR(clr[2]), .FRAMING_ERROR_CLEAR(clr[1]), .OVERRUN_ERROR_CLEAR(clr[0]));
    dcsp_remote #(.BT(BT)) peer (.clk(MCLK), .inv(LINE_INVERT), .nb(tx_nb), .line_in(TXD),
        .line_out(RXD), .got(got), .got_ev(got_ev));
    ////////////////////////////////////////
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int nbits(input logic [1:0] len);
        return (len == DCSP_LEN7) ? 7 : (len == DCSP_LEN9) ? 9 : 8;
    endfunction
    // raw bits after the start bit, stop bits as ones above
    function automatic logic [11:0] frame(input logic [8:0] d);
        int n;
        logic [11:0] f;
        n = nbits(CHAR_LEN);
        f = ({3'h0, d} & ~(12'hFFF << n)) | (12'hFFF << n);
        if (PARITY_SEL != DCSP_PAR_NONE) begin
            f[n] = (PARITY_SEL == DCSP_PAR_ZERO) ? 1'b0 :
                (^(f & ~(12'hFFF << n))) ^ (PARITY_SEL == DCSP_PAR_ODD);
        end
        return f;
    endfunction
    assign tx_nb = 4'(nbits(CHAR_LEN) + (PARITY_SEL != DCSP_PAR_NONE) + TWO_STOP + 1);
    task automatic compare(input string what, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tx_char(input logic [8:0] d);
        while (TX_READY !== 1'b1) @(negedge MCLK);
        TX_DATA = d;
        TX_WRITE = 1'b1;
        tx_q.push_back(frame(d));
        irq_exp++;
        @(negedge MCLK);
        TX_WRITE = 1'b0;
        @(negedge MCLK);
    endtask
    // err 1 flips the parity bit, err 2 sends a low stop bit
    task automatic rx_char(input logic [8:0] d, input int err);
        logic [11:0] f;
        int n;
        f = frame(d);
        n = nbits(CHAR_LEN) + (PARITY_SEL != DCSP_PAR_NONE);
        if (err == 1) f[n - 1] = ~f[n - 1];
        if (err == 2) f[n] = 1'b0;
        rx_q.push_back(f & ~(12'hFFF << nbits(CHAR_LEN)));
        peer.send(f, n + 1, BT);
    endtask
    task automatic err_check(input logic [2:0] e);
        repeat (2 * BT) @(negedge MCLK);
        compare("error flags", {9'h0, e},
            {9'h0, PARITY_ERROR, FRAMING_ERROR, OVERRUN_ERROR});
        clr = 3'h7;
        @(negedge MCLK);
        clr = 3'h0;
        @(negedge MCLK);
        compare("cleared", 12'h000, {9'h0, PARITY_ERROR, FRAMING_ERROR, OVERRUN_ERROR});
    endtask
    ////////////////////////////////////////
    always @(got_ev) begin
        if (!RST) compare("tx frame", tx_q.size() != 0 ? tx_q.pop_front() : 12'hXXX, got);
    end
    always @(negedge MCLK) begin
        RX_READ <= 1'b0;
        if (TX_INTERRUPT === 1'b1) irq_cnt++;
        if (RX_DONE_INTERRUPT === 1'b1) begin
            compare("rx data", rx_q.size() != 0 ? rx_q.pop_front() : 12'hXXX, {3'h0, RX_DATA});
            RX_READ <= auto_read;
        end
    end
    initial begin
        repeat (8) @(negedge MCLK);
        RST = 1'b0;
        for (int k = 0; k < 12; k++) begin
            CHAR_LEN = 2'(k % 3);
            PARITY_SEL = 2'(k / 3);
            TWO_STOP = k[0];
            RX_NOISE_FILTER_ENABLE = k[1];
            CONT_MODE = k[2];
            LINE_INVERT = k[3];
            repeat (4) @(negedge MCLK);
            lfsr = step(lfsr);
            fork
                tx_char(lfsr[8:0]);
                rx_char(lfsr[24:16], 0);
            join
            repeat (16 * BT) @(negedge MCLK);
            compare("tx interrupts", 12'(irq_exp), 12'(irq_cnt));
        end
        CONT_MODE = 1'b1;
        for (int k = 0; k < 5; k++) begin
            lfsr = step(lfsr);
            tx_char(lfsr[8:0]);
        end
        repeat (50 * BT) @(negedge MCLK);
        compare("burst interrupts", 12'(irq_exp), 12'(irq_cnt));
        CHAR_LEN = DCSP_LEN8;
        LINE_INVERT = 1'b0;
        repeat (4) @(negedge MCLK);
        for (int p = 1; p < 4; p++) begin
            PARITY_SEL = 2'(p);
            lfsr = step(lfsr);
            rx_char(lfsr[8:0], 1);
            err_check(3'h4);
        end
        rx_char(9'h05A, 2);
        err_check(3'h2);
        auto_read = 1'b0;
        rx_char(9'h033, 0);
        rx_char(9'h0CC, 0);
        err_check(3'h1);
        for (int k = 0; k < 2; k++) begin
            RX_NOISE_FILTER_ENABLE = k[0];
            peer.send(12'hFFF, 0, 2 - k);
            repeat (16 * BT) @(negedge MCLK);
        end
        compare("rx left", 12'h000, 12'(rx_q.size()));
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        error_cnt++;
        report_and_stop();
    end
endmodule
